/* File: logic/sysdec_pkg.sv */
package sysdec_pkg;

  // ********************************************************
  // Widths
  // ********************************************************
  localparam int ADDR_W = 24;
  localparam int IO_W = 16;
  localparam int REG_AW = 4;
  localparam int REG_DW = 8;
  localparam int TGT_W = 5;

  // ********************************************************
  // Memory map
  // ********************************************************
  localparam logic [ADDR_W-1:0] ALIAS_TOP_LO = 24'hfe0000;
  localparam logic [ADDR_W-1:0] ALIAS_TOP_SHIFT = 24'hf00000;
  localparam logic [ADDR_W-1:0] ALIAS_E_LO = 24'h0e0000;
  localparam logic [ADDR_W-1:0] ALIAS_E_HI = 24'h0effff;
  localparam logic [ADDR_W-1:0] ALIAS_E_SHIFT = 24'h010000;
  localparam logic [ADDR_W-1:0] ROM_LO = 24'h0f0000;
  localparam logic [ADDR_W-1:0] ROM_HI = 24'h0fffff;
  localparam logic [ADDR_W-1:0] RESET_VEC = 24'h0ffff0;
  localparam logic [ADDR_W-1:0] SOCK2_LO = 24'h0d8000;
  localparam logic [ADDR_W-1:0] SOCK2_HI = 24'h0dffff;
  localparam logic [ADDR_W-1:0] SOCK1_LO = 24'h0c0000;
  localparam logic [ADDR_W-1:0] SOCK1_HI = 24'h0c7fff;
  localparam logic [ADDR_W-1:0] VIDEO_LO = 24'h0a0000;
  localparam logic [ADDR_W-1:0] VIDEO_HI = 24'h0bffff;
  localparam logic [ADDR_W-1:0] DRAM_LO = 24'h000000;
  localparam logic [ADDR_W-1:0] DRAM_HI = 24'h07ffff;
  localparam logic [ADDR_W-1:0] DRAM_OPT_LO = 24'h080000;
  localparam logic [ADDR_W-1:0] DRAM_OPT_HI = 24'h09ffff;
  localparam logic [ADDR_W-1:0] EXT_LO = 24'h100000;
  localparam logic [ADDR_W-1:0] EXT_HI_DEFAULT = 24'h15ffff;
  localparam logic [ADDR_W-1:0] EXT_HI_MAX = 24'hfdffff;

  // ********************************************************
  // I/O map
  // ********************************************************
  localparam logic [IO_W-1:0] IO_CFG_LO = 16'h0372;
  localparam logic [IO_W-1:0] IO_CFG_HI = 16'h0373;
  localparam logic [IO_W-1:0] IO_SCSI_LO = 16'h0370;
  localparam logic [IO_W-1:0] IO_SCSI_HI = 16'h0371;
  localparam logic [IO_W-1:0] IO_FLOP_LO = 16'h03f0;
  localparam logic [IO_W-1:0] IO_FLOP_HI = 16'h03f7;
  localparam logic [IO_W-1:0] IO_RTC_LO = 16'h0070;
  localparam logic [IO_W-1:0] IO_RTC_HI = 16'h007f;
  localparam logic [IO_W-1:0] IO_PIC1_LO = 16'h0020;
  localparam logic [IO_W-1:0] IO_PIC1_HI = 16'h003f;
  localparam logic [IO_W-1:0] IO_TMR_LO = 16'h0040;
  localparam logic [IO_W-1:0] IO_TMR_HI = 16'h005f;
  localparam logic [IO_W-1:0] IO_KBD_LO = 16'h0060;
  localparam logic [IO_W-1:0] IO_KBD_HI = 16'h006f;
  localparam logic [IO_W-1:0] IO_PAGE_LO = 16'h0080;
  localparam logic [IO_W-1:0] IO_PAGE_HI = 16'h009f;
  localparam logic [IO_W-1:0] IO_PIC2_LO = 16'h00a0;
  localparam logic [IO_W-1:0] IO_PIC2_HI = 16'h00bf;
  localparam logic [IO_W-1:0] IO_DMA2_LO = 16'h00c0;
  localparam logic [IO_W-1:0] IO_DMA2_HI = 16'h00df;

  // ********************************************************
  // Targets
  // ********************************************************
  typedef enum logic [TGT_W-1:0] {
    TGT_NONE = 5'h00, TGT_DRAM = 5'h01, TGT_ROM = 5'h02, TGT_SOCK1 = 5'h03,
    TGT_SOCK2 = 5'h04, TGT_VIDEO = 5'h05, TGT_EXPBUS = 5'h06, TGT_CFG = 5'h07,
    TGT_SCSI = 5'h08, TGT_FLOPPY = 5'h09, TGT_RTC = 5'h0a, TGT_PIC1 = 5'h0b,
    TGT_TIMER = 5'h0c, TGT_KBD = 5'h0d, TGT_DMAPAGE = 5'h0e, TGT_PIC2 = 5'h0f,
    TGT_DMA2 = 5'h10
  } target_t;

  // ********************************************************
  // Registers
  // ********************************************************
  localparam logic [REG_AW-1:0] SPEED_CTRL_OFS = 4'h0;
  localparam logic [REG_AW-1:0] SPEED_STAT_OFS = 4'h4;
  localparam int CTRL_CPU_HALF_BIT = 0;
  localparam int CTRL_BUS_HALF_BIT = 1;
  localparam logic CPU_HALF_RST = 1'b0;
  localparam logic BUS_HALF_RST = 1'b1;
  localparam int STAT_RATE_BIT = 0;
  localparam int STAT_SLOW_BIT = 1;
  localparam int STAT_ACT_BIT = 2;

endpackage

/* File: logic/sysdec.sv */
`timescale 1ns/1ps
// Overview of operation
// - Take a 24-bit memory address; every address lands on exactly one target.
// - FE0000h-FFFFFFh mirror the onboard memory at 0E0000h-0FFFFFh.
// - 0E0000h-0EFFFFh mirror the boot ROM at 0F0000h-0FFFFFh.
// - Extended DRAM from 100000h when 1MB fitted and extended jumper set.
// - 0F0000h-0FFFFFh selects the boot ROM pair; odd and even byte lanes split.
// - 0D8000h-0DFFFFh selects the second byte-wide socket.
// - 0C0000h-0C7FFFh selects the first byte-wide socket.
// - Remaining 0C0000h-0CFFFFh is left to expansion card ROMs.
// - 0A0000h-0BFFFFh goes to video memory.
// - DRAM at 000000h-07FFFFh; optional 128K at 080000h-09FFFFh when fitted.
// - Unclaimed memory addresses go to the expansion bus.
// - I/O 0372h-0373h selects the configuration serial memory register.
// - I/O 0370h-0371h selects the SCSI controller ports.
// - I/O 03F0h-03F7h selects the floppy controller.
// - I/O 0070h-007Fh selects real time clock and NMI mask.
// - I/O decode places interrupt controller 1, timer and keyboard controller.
// - I/O decode places DMA page registers, interrupt controller 2, DMA 2.
// - Processor clock is the master clock halved.
// - Software may slow processor plus bus, or the bus alone, to half.
// - Full-speed processor drops to half rate for slowed bus transactions.
// - Bus clock runs at half frequency during a slowed bus transaction.
// - Bus never faster than processor; processor half forces bus half.
module sysdec
  import sysdec_pkg::*;
#(
  parameter logic [ADDR_W-1:0] EXT_HI = EXT_HI_DEFAULT
) (
  input logic clk,
  input logic rst_n,
  input logic cyc_start,
  input logic cyc_done,
  input logic cyc_io,
  input logic [ADDR_W-1:0] cyc_addr,
  input logic cyc_bhe_n,
  input logic dram_opt_fitted,
  input logic dram_1mb_fitted,
  input logic ext_mem_jumper,
  input logic [REG_AW-1:0] reg_addr,
  input logic [REG_DW-1:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [REG_DW-1:0] reg_rdata,
  output target_t target,
  output logic [ADDR_W-1:0] local_addr,
  output logic cyc_active,
  output logic rom_odd_sel,
  output logic rom_even_sel,
  output logic cpu_clk,
  output logic bus_clk
);

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic [2:0] strap_meta;
    logic [2:0] strap;
    logic cpu_half;
    logic bus_half;
    target_t target;
    logic [ADDR_W-1:0] local_addr;
    logic cyc_active;
    logic rom_odd_sel;
    logic rom_even_sel;
    logic cpu_clk;
    logic bus_clk;
    logic half_cnt;
    logic rate_half;
    logic [REG_DW-1:0] reg_rdata;
  } state_t;

  state_t s;
  state_t next_s;

  function automatic logic in_mem(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] lo,
                                  input logic [ADDR_W-1:0] hi);
    in_mem = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic in_io(input logic [IO_W-1:0] a, input logic [IO_W-1:0] lo,
                                 input logic [IO_W-1:0] hi);
    in_io = (a >= lo) && (a <= hi);
  endfunction

  // ********************************************************
  // Address translation and decode
  // ********************************************************
  logic [ADDR_W-1:0] mapped;
  target_t mem_tgt;
  target_t io_tgt;
  logic [IO_W-1:0] io_a;
  logic opt_ok;
  logic ext_ok;

  assign io_a = cyc_addr[IO_W-1:0];
  // Jumper levels come off pins, so only the synchronised copy is read
  assign opt_ok = s.strap[0];
  assign ext_ok = s.strap[1] && s.strap[2];

  always_comb begin
    mapped = cyc_addr;
    if (cyc_addr >= ALIAS_TOP_LO) begin
      mapped = cyc_addr - ALIAS_TOP_SHIFT;
    end
    if (in_mem(mapped, ALIAS_E_LO, ALIAS_E_HI)) begin
      mapped = mapped + ALIAS_E_SHIFT;
    end
  end

  always_comb begin
    if (in_mem(mapped, SOCK1_LO, SOCK1_HI)) begin
      mem_tgt = TGT_SOCK1;
    end else if (in_mem(mapped, SOCK2_LO, SOCK2_HI)) begin
      mem_tgt = TGT_SOCK2;
    end else if (in_mem(mapped, ROM_LO, ROM_HI)) begin
      mem_tgt = TGT_ROM;
    end else if (in_mem(mapped, DRAM_LO, DRAM_HI) || (opt_ok && in_mem(mapped, DRAM_OPT_LO, DRAM_OPT_HI))) begin
      mem_tgt = TGT_DRAM;
    end else if (ext_ok && in_mem(mapped, EXT_LO, EXT_HI) && (mapped <= EXT_HI_MAX)) begin
      mem_tgt = TGT_DRAM;
    end else if (in_mem(mapped, VIDEO_LO, VIDEO_HI)) begin
      mem_tgt = TGT_VIDEO;
    end else begin
      mem_tgt = TGT_EXPBUS;
    end
  end

  always_comb begin
    if (in_io(io_a, IO_CFG_LO, IO_CFG_HI)) begin
      io_tgt = TGT_CFG;
    end else if (in_io(io_a, IO_SCSI_LO, IO_SCSI_HI)) begin
      io_tgt = TGT_SCSI;
    end else if (in_io(io_a, IO_FLOP_LO, IO_FLOP_HI)) begin
      io_tgt = TGT_FLOPPY;
    end else if (in_io(io_a, IO_RTC_LO, IO_RTC_HI)) begin
      io_tgt = TGT_RTC;
    end else if (in_io(io_a, IO_PIC1_LO, IO_PIC1_HI)) begin
      io_tgt = TGT_PIC1;
    end else if (in_io(io_a, IO_TMR_LO, IO_TMR_HI)) begin
      io_tgt = TGT_TIMER;
    end else if (in_io(io_a, IO_KBD_LO, IO_KBD_HI)) begin
      io_tgt = TGT_KBD;
    end else if (in_io(io_a, IO_PAGE_LO, IO_PAGE_HI)) begin
      io_tgt = TGT_DMAPAGE;
    end else if (in_io(io_a, IO_PIC2_LO, IO_PIC2_HI)) begin
      io_tgt = TGT_PIC2;
    end else if (in_io(io_a, IO_DMA2_LO, IO_DMA2_HI)) begin
      io_tgt = TGT_DMA2;
    end else begin
      io_tgt = TGT_EXPBUS;
    end
  end

  // ********************************************************
  // Speed control and next state
  // ********************************************************
  logic bus_tgt;
  logic bus_half_eff;
  logic slow_active;
  logic want_half;
  logic toggle;

  // Video memory sits on the expansion bus, so it is slowed too
  assign bus_tgt = (s.target == TGT_EXPBUS) || (s.target == TGT_VIDEO);
  assign bus_half_eff = s.bus_half || s.cpu_half;
  // Slow only inside a bus cycle
  assign slow_active = s.cyc_active && bus_tgt && bus_half_eff;
  assign want_half = s.cpu_half || slow_active;
  assign toggle = s.rate_half ? s.half_cnt : 1'b1;

  always_comb begin
    next_s = s;
    next_s.strap_meta = {ext_mem_jumper, dram_1mb_fitted, dram_opt_fitted};
    next_s.strap = s.strap_meta;

    if (reg_wr && (reg_addr == SPEED_CTRL_OFS)) begin
      next_s.cpu_half = reg_wdata[CTRL_CPU_HALF_BIT];
      next_s.bus_half = reg_wdata[CTRL_BUS_HALF_BIT];
    end
    next_s.reg_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        SPEED_CTRL_OFS: begin
          next_s.reg_rdata[CTRL_CPU_HALF_BIT] = s.cpu_half;
          next_s.reg_rdata[CTRL_BUS_HALF_BIT] = s.bus_half;
        end
        SPEED_STAT_OFS: begin
          next_s.reg_rdata[STAT_RATE_BIT] = s.rate_half;
          next_s.reg_rdata[STAT_SLOW_BIT] = slow_active;
          next_s.reg_rdata[STAT_ACT_BIT] = s.cyc_active;
        end
        default: begin
          next_s.reg_rdata = '0;
        end
      endcase
    end

    // A new cycle wins over the end of the old one
    if (cyc_start) begin
      next_s.cyc_active = 1'b1;
      next_s.target = cyc_io ? io_tgt : mem_tgt;
      next_s.local_addr = cyc_io ? cyc_addr : mapped;
      // Odd lane high socket, even lane low socket
      next_s.rom_odd_sel = !cyc_io && (mem_tgt == TGT_ROM) && !cyc_bhe_n;
      next_s.rom_even_sel = !cyc_io && (mem_tgt == TGT_ROM) && !cyc_addr[0];
    end else if (cyc_done) begin
      next_s.cyc_active = 1'b0;
      next_s.target = TGT_NONE;
      next_s.rom_odd_sel = 1'b0;
      next_s.rom_even_sel = 1'b0;
    end

    // Rate taken only at a falling edge
    if (toggle) begin
      next_s.cpu_clk = !s.cpu_clk;
      // Bus clock follows the slowed processor clock
      next_s.bus_clk = !s.cpu_clk;
      next_s.half_cnt = 1'b0;
      if (s.cpu_clk) begin
        next_s.rate_half = want_half;
      end
    end else begin
      next_s.half_cnt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.target <= TGT_NONE;
      s.cpu_half <= CPU_HALF_RST;
      s.bus_half <= BUS_HALF_RST;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.reg_rdata;
  assign target = s.target;
  assign local_addr = s.local_addr;
  assign cyc_active = s.cyc_active;
  assign rom_odd_sel = s.rom_odd_sel;
  assign rom_even_sel = s.rom_even_sel;
  assign cpu_clk = s.cpu_clk;
  assign bus_clk = s.bus_clk;

  // ********************************************************
  // Assertions
  // ********************************************************
  property p_top_alias;
    @(posedge clk) disable iff (!rst_n)
    cyc_start && !cyc_io && (cyc_addr >= ALIAS_TOP_LO) |=> (target == TGT_ROM) && (local_addr[19:16] >= 4'he);
  endproperty
  a_top_alias: assert property (p_top_alias) else $error("top alias not folded");

  property p_e_alias;
    @(posedge clk) disable iff (!rst_n)
    cyc_start && !cyc_io && in_mem(cyc_addr, ALIAS_E_LO, ALIAS_E_HI)
      |=> target == TGT_ROM && local_addr == $past(cyc_addr) + ALIAS_E_SHIFT;
  endproperty
  a_e_alias: assert property (p_e_alias) else $error("E page alias wrong");

  property p_vec;
    @(posedge clk) disable iff (!rst_n)
    cyc_start && !cyc_io && cyc_addr == RESET_VEC && !cyc_bhe_n |=> target == TGT_ROM ##0 rom_odd_sel && rom_even_sel;
  endproperty
  a_vec: assert property (p_vec) else $error("startup vector missed ROM");

  property p_sock;
    @(posedge clk) disable iff (!rst_n)
    cyc_start && !cyc_io |=> (in_mem($past(mapped), SOCK2_LO, SOCK2_HI) == (target == TGT_SOCK2))
      && (in_mem($past(mapped), SOCK1_LO, SOCK1_HI) == (target == TGT_SOCK1));
  endproperty
  a_sock: assert property (p_sock) else $error("socket decode wrong");

  property p_ext;
    @(posedge clk) disable iff (!rst_n)
    cyc_start && !cyc_io && in_mem(cyc_addr, EXT_LO, EXT_HI) |=> (target == TGT_DRAM) == $past(ext_ok);
  endproperty
  a_ext: assert property (p_ext) else $error("extended DRAM gating wrong");

  property p_video;
    @(posedge clk) disable iff (!rst_n)
    cyc_start && !cyc_io && in_mem(cyc_addr, VIDEO_LO, VIDEO_HI) |=> target == TGT_VIDEO;
  endproperty
  a_video: assert property (p_video) else $error("video range lost");

  property p_io_cfg;
    @(posedge clk) disable iff (!rst_n)
    cyc_start && cyc_io && in_io(cyc_addr[IO_W-1:0], IO_CFG_LO, IO_CFG_HI) |=> target == TGT_CFG [*1];
  endproperty
  a_io_cfg: assert property (p_io_cfg) else $error("config port decode wrong");

  property p_floppy;
    @(posedge clk) disable iff (!rst_n)
    cyc_start && cyc_io && in_io(cyc_addr[IO_W-1:0], IO_FLOP_LO, IO_FLOP_HI) |=> target == TGT_FLOPPY;
  endproperty
  a_floppy: assert property (p_floppy) else $error("floppy decode wrong");

  property p_half_period;
    @(posedge clk) disable iff (!rst_n)
    $changed(cpu_clk) && s.rate_half |=> $stable(cpu_clk) ##1 $changed(cpu_clk);
  endproperty
  a_half_period: assert property (p_half_period) else $error("half rate phase wrong");

  property p_full_period;
    @(posedge clk) disable iff (!rst_n)
    // The edge that leaves reset has no toggle behind it yet
    !s.rate_half [*2] ##0 $past(rst_n) |-> $changed(cpu_clk);
  endproperty
  a_full_period: assert property (p_full_period) else $error("full rate not master half");

  property p_slow_bus;
    @(posedge clk) disable iff (!rst_n)
    slow_active [*5] |-> s.rate_half;
  endproperty
  a_slow_bus: assert property (p_slow_bus) else $error("bus cycle not slowed");

  property p_bus_clk;
    @(posedge clk) disable iff (!rst_n)
    bus_clk == cpu_clk;
  endproperty
  a_bus_clk: assert property (p_bus_clk) else $error("bus clock faster than processor");

  c_rom: cover property (@(posedge clk) disable iff (!rst_n) target == TGT_ROM);
  c_slow: cover property (@(posedge clk) disable iff (!rst_n) slow_active ##1 !slow_active);
  c_cpu_half: cover property (@(posedge clk) disable iff (!rst_n) s.cpu_half && s.rate_half);
  c_ext: cover property (@(posedge clk) disable iff (!rst_n) target == TGT_DRAM && local_addr >= EXT_LO);

endmodule

/* File: sim/cpu_model.sv */
`timescale 1ns/1ps
// ********************************************************
// Processor side cycle source
// ********************************************************
module cpu_model
  import sysdec_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic stop,
  input wire logic io_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic bhe_in_n,
  output logic cyc_start,
  output logic cyc_done,
  output logic cyc_io,
  output logic [ADDR_W-1:0] cyc_addr,
  output logic cyc_bhe_n
);
  // Qualifiers are only valid beside the start pulse; afterwards they are
  // inverted every cycle so a decoder that samples late cannot match
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_start <= 1'b0;
      cyc_done <= 1'b0;
      cyc_io <= 1'b0;
      cyc_addr <= 24'h000000;
      cyc_bhe_n <= 1'b1;
    end else begin
      cyc_start <= go;
      cyc_done <= stop;
      if (go) begin
        cyc_io <= io_in;
        cyc_addr <= addr_in;
        cyc_bhe_n <= bhe_in_n;
      end else begin
        cyc_io <= ~cyc_io;
        cyc_addr <= ~cyc_addr;
        cyc_bhe_n <= ~cyc_bhe_n;
      end
    end
  end
endmodule

/* File: sim/sysdec_test.sv */
`timescale 1ns/1ps
module sysdec_test
  import sysdec_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic stop = 1'b0;
  logic io_in = 1'b0;
  logic [ADDR_W-1:0] addr_in = 24'h000000;
  logic bhe_in_n = 1'b1;
  logic cyc_start, cyc_done, cyc_io, cyc_bhe_n, cyc_active;
  logic [ADDR_W-1:0] cyc_addr, local_addr;
  logic dram_opt_fitted = 1'b1;
  logic dram_1mb_fitted = 1'b1;
  logic ext_mem_jumper = 1'b1;
  logic [REG_AW-1:0] reg_addr = 4'h0;
  logic [REG_DW-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [REG_DW-1:0] reg_rdata;
  target_t target;
  logic rom_odd_sel, rom_even_sel, cpu_clk, bus_clk;
  int errors = 0;
  int cmp_count = 0;

  always #20 clk = ~clk;

  cpu_model cpu_model_i (.clk(clk), .rst_n(rst_n), .go(go), .stop(stop), .io_in(io_in),
    .addr_in(addr_in), .bhe_in_n(bhe_in_n), .cyc_start(cyc_start), .cyc_done(cyc_done),
    .cyc_io(cyc_io), .cyc_addr(cyc_addr), .cyc_bhe_n(cyc_bhe_n));

  sysdec sysdec_i (.clk(clk), .rst_n(rst_n), .cyc_start(cyc_start), .cyc_done(cyc_done),
    .cyc_io(cyc_io), .cyc_addr(cyc_addr), .cyc_bhe_n(cyc_bhe_n),
    .dram_opt_fitted(dram_opt_fitted), .dram_1mb_fitted(dram_1mb_fitted),
    .ext_mem_jumper(ext_mem_jumper), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .target(target),
    .local_addr(local_addr), .cyc_active(cyc_active), .rom_odd_sel(rom_odd_sel),
    .rom_even_sel(rom_even_sel), .cpu_clk(cpu_clk), .bus_clk(bus_clk));

  // ********************************************************
  // Reporting
  // ********************************************************
  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // ********************************************************
  // Register port
  // ********************************************************
  task wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe, so sample mid-cycle there
  task rd(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check("reg_rdata", exp, reg_rdata);
  endtask

  // ********************************************************
  // Processor cycles
  // ********************************************************
  task wait_act(input logic v);
    int n;
    n = 0;
    while (cyc_active !== v && n < 20) begin
      @(negedge clk);
      n++;
    end
    // A level reached on the last try is no timeout
    if (cyc_active !== v) begin
      check("cyc_active", v, cyc_active);
      close_out;
    end
  endtask

  task cyc_begin(input logic io, input logic [ADDR_W-1:0] a, input logic bh);
    @(posedge clk);
    go <= 1'b1;
    io_in <= io;
    addr_in <= a;
    bhe_in_n <= bh;
    @(posedge clk);
    go <= 1'b0;
    wait_act(1'b1);
  endtask

  task cyc_end;
    @(posedge clk);
    stop <= 1'b1;
    @(posedge clk);
    stop <= 1'b0;
    wait_act(1'b0);
    check("idle target", TGT_NONE, target);
  endtask

  task dec(input logic io, input logic [ADDR_W-1:0] a, input logic bh, input target_t t,
           input logic [ADDR_W-1:0] la);
    cyc_begin(io, a, bh);
    check("target", t, target);
    check("local_addr", la, local_addr);
    check("rom_odd_sel", t == TGT_ROM && !bh, rom_odd_sel);
    check("rom_even_sel", t == TGT_ROM && !la[0], rom_even_sel);
    cyc_end;
  endtask

  // Toggles seen over 8 clocks: 8 at full rate, 4 at half rate
  task rate(input int exp);
    int t;
    logic p;
    t = 0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    p = cpu_clk;
    repeat (8) begin
      @(negedge clk);
      if (cpu_clk !== p) t++;
      p = cpu_clk;
      check("bus_clk", cpu_clk, bus_clk);
    end
    check("cpu_clk toggles", exp, t);
  endtask

  // ********************************************************
  // Sequence
  // ********************************************************
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(SPEED_CTRL_OFS, 8'h02);
    repeat (3) @(posedge clk);
    dec(0, 24'hfffff0, 0, TGT_ROM, 24'h0ffff0);
    dec(0, 24'h0ffff0, 0, TGT_ROM, 24'h0ffff0);
    dec(0, 24'hfe0001, 0, TGT_ROM, 24'h0f0001);
    dec(0, 24'hffffff, 1, TGT_ROM, 24'h0fffff);
    dec(0, 24'h0e1234, 0, TGT_ROM, 24'h0f1234);
    dec(0, 24'h0f0000, 1, TGT_ROM, 24'h0f0000);
    dec(0, 24'h0d8000, 0, TGT_SOCK2, 24'h0d8000);
    dec(0, 24'h0dffff, 0, TGT_SOCK2, 24'h0dffff);
    dec(0, 24'h0c0000, 0, TGT_SOCK1, 24'h0c0000);
    dec(0, 24'h0c7fff, 0, TGT_SOCK1, 24'h0c7fff);
    dec(0, 24'h0c8000, 0, TGT_EXPBUS, 24'h0c8000);
    dec(0, 24'h0a0000, 0, TGT_VIDEO, 24'h0a0000);
    dec(0, 24'h0bffff, 0, TGT_VIDEO, 24'h0bffff);
    dec(0, 24'h000000, 0, TGT_DRAM, 24'h000000);
    dec(0, 24'h09ffff, 0, TGT_DRAM, 24'h09ffff);
    dec(0, 24'h100000, 0, TGT_DRAM, 24'h100000);
    dec(0, 24'h15ffff, 0, TGT_DRAM, 24'h15ffff);
    dec(0, 24'h160000, 0, TGT_EXPBUS, 24'h160000);
    dec(0, 24'h800000, 0, TGT_EXPBUS, 24'h800000);
    dec(1, 24'h000372, 0, TGT_CFG, 24'h000372);
    dec(1, 24'h000373, 0, TGT_CFG, 24'h000373);
    dec(1, 24'h000370, 0, TGT_SCSI, 24'h000370);
    dec(1, 24'h000371, 0, TGT_SCSI, 24'h000371);
    dec(1, 24'h0003f0, 0, TGT_FLOPPY, 24'h0003f0);
    dec(1, 24'h0003f7, 0, TGT_FLOPPY, 24'h0003f7);
    dec(1, 24'h0003f8, 0, TGT_EXPBUS, 24'h0003f8);
    dec(1, 24'h000070, 0, TGT_RTC, 24'h000070);
    dec(1, 24'h00007f, 0, TGT_RTC, 24'h00007f);
    dec(1, 24'h000020, 0, TGT_PIC1, 24'h000020);
    dec(1, 24'h00005f, 0, TGT_TIMER, 24'h00005f);
    dec(1, 24'h000060, 0, TGT_KBD, 24'h000060);
    dec(1, 24'h00009f, 0, TGT_DMAPAGE, 24'h00009f);
    dec(1, 24'h0000a0, 0, TGT_PIC2, 24'h0000a0);
    dec(1, 24'h0000df, 0, TGT_DMA2, 24'h0000df);
    $display("test decode done");
    @(posedge clk);
    dram_opt_fitted <= 1'b0;
    dram_1mb_fitted <= 1'b0;
    repeat (4) @(posedge clk);
    dec(0, 24'h080000, 0, TGT_EXPBUS, 24'h080000);
    dec(0, 24'h100000, 0, TGT_EXPBUS, 24'h100000);
    @(posedge clk);
    dram_1mb_fitted <= 1'b1;
    ext_mem_jumper <= 1'b0;
    repeat (4) @(posedge clk);
    dec(0, 24'h100000, 0, TGT_EXPBUS, 24'h100000);
    $display("test jumpers done");
    rate(8);
    cyc_begin(0, 24'h800000, 0);
    rate(4);
    rd(SPEED_STAT_OFS, 8'h07);
    cyc_end;
    rate(8);
    cyc_begin(0, 24'h001000, 0);
    rate(8);
    rd(SPEED_STAT_OFS, 8'h04);
    cyc_end;
    wr(SPEED_CTRL_OFS, 8'h00);
    cyc_begin(0, 24'h800000, 0);
    rate(8);
    cyc_end;
    wr(SPEED_CTRL_OFS, 8'h01);
    rate(4);
    cyc_begin(0, 24'h0a0000, 0);
    rate(4);
    cyc_end;
    $display("test speed done");
    wr(SPEED_CTRL_OFS, 8'h03);
    rd(SPEED_CTRL_OFS, 8'h03);
    wr(4'h8, 8'hff);
    rd(4'h8, 8'h00);
    wr(SPEED_STAT_OFS, 8'hff);
    rd(SPEED_CTRL_OFS, 8'h03);
    $display("test registers done");
    close_out;
  end
endmodule
